// file: hdl/gauge_pkg.sv
`default_nettype none
package gauge_pkg;
  localparam int CAP_W  = 16;
  localparam int CUR_W  = 16;
  localparam int WAIT_W = 8;
  localparam int QT_W   = 8;
  typedef enum logic [1:0] {
    MODE_NORMAL    = 2'b00,
    MODE_SLEEP     = 2'b01,
    MODE_DEEP_SLEEP_BIT = 2'b10,
    MODE_HIBERNATE = 2'b11
  } power_mode_t;
  localparam power_mode_t MODE_RST = MODE_NORMAL;
  localparam int CLK_HZ          = 40_000_000;
  localparam int STRETCH_MAX_US  = 4000;
  // Longest time, so rounded down
  localparam int STRETCH_CYC = (STRETCH_MAX_US * (CLK_HZ / 1_000_000));
  localparam logic ALERT_RST   = 1'b0;
  localparam logic PULLUP_RST  = 1'b0;
  localparam logic POLARITY_RST = 1'b0;
endpackage : gauge_pkg
`default_nettype wire

// file: hdl/gauge_alert_power.sv
// Behaviour
// R01 - Single-wire pin: polarity picks hi-Z or low
// R02 - Shutdown pin levels follow pullup and polarity
// R03 - Threshold, high, low flags always alert
// R04 - Overtemp flags alert when qualification time nonzero
// R05 - Short and tab flags need enable bits
// R06 - Peak current flag needs its enable
// R07 - Trip point asserts on capacity thresholds
// R08 - Trip mode masks every other source
// R09 - Trip alert holds until both thresholds rewritten
// R10 - Normal mode measures and decides transitions
// R11 - Sleep needs enable and low average current
// R12 - Offset calibration before entering sleep
// R13 - Sleep modes may stretch host transfers 4 ms
// R14 - Leave sleep on current rise or wake
// R15 - Nonzero wait: countdown then deep sleep
// R16 - Zero wait: deep sleep only if bit set
// R17 - Deep sleep exits on traffic; bit rule
// R18 - Host re-issues deep sleep command when wait zero
// R19 - Deep sleep also exits on current or wake
// R20 - Hibernate needs OPEN_CIRCUIT_VOLTAGE, low current, trigger
// R21 - Hibernate held until addressed traffic
// R22 - Shutdown state only for low-voltage hibernate
// R23 - Waking from hibernate clears hibernate bit
// R24 - Alert level registered, glitch free
// R25 - Four-state mode register, resets to normal
`default_nettype none
module gauge_alert_power
  import gauge_pkg::*;
#(
  parameter int STRETCH_CYCLES = gauge_pkg::STRETCH_CYC
) (
  input  wire logic                             CORE_CLK,
  input  wire logic                             RST,
  input  wire logic                             ALERT_PIN_SELECT,
  input  wire logic                             ALERT_POLARITY,
  input  wire logic                             SHUTDOWN_PIN_PULLUP,
  input  wire logic                             SHUTDOWN_ENABLE,
  input  wire logic                             CHARGE_THRESHOLD_ONE_FLAG,
  input  wire logic                             BATTERY_HIGH_FLAG,
  input  wire logic                             BATTERY_LOW_FLAG,
  input  wire logic                             OVERTEMP_CHARGE_FLAG,
  input  wire logic                             OVERTEMP_DISCHARGE_FLAG,
  input  wire logic [gauge_pkg::QT_W-1:0]       OVERTEMP_CHARGE_QUAL_TIME,
  input  wire logic [gauge_pkg::QT_W-1:0]       OVERTEMP_DISCHARGE_QUAL_TIME,
  input  wire logic                             INTERNAL_SHORT_FLAG,
  input  wire logic                             TAB_DISCONNECT_FLAG,
  input  wire logic                             SHORT_ALERT_ENABLE,
  input  wire logic                             TAB_ALERT_ENABLE,
  input  wire logic                             PEAK_CURRENT_FLAG,
  input  wire logic                             PEAK_CURRENT_ALERT_ENABLE,
  input  wire logic                             TRIP_POINT_ENABLE,
  input  wire logic [gauge_pkg::CAP_W-1:0]      TRIP_SET_THRESHOLD,
  input  wire logic [gauge_pkg::CAP_W-1:0]      TRIP_CLEAR_THRESHOLD,
  input  wire logic                             TRIP_SET_WR,
  input  wire logic                             TRIP_CLEAR_WR,
  input  wire logic [gauge_pkg::CAP_W-1:0]      REMAINING_CAPACITY_A,
  input  wire logic signed [gauge_pkg::CUR_W-1:0] AVERAGE_CURRENT_B,
  input  wire logic [gauge_pkg::CUR_W-1:0]      SLEEP_CURRENT,
  input  wire logic [gauge_pkg::CUR_W-1:0]      HIBERNATE_CURRENT,
  input  wire logic                             SLEEP_ENABLE,
  input  wire logic                             WAKE_CMP_ENABLE,
  input  wire logic                             WAKE_DETECT,
  input  wire logic                             CAL_DONE,
  input  wire logic [gauge_pkg::WAIT_W-1:0]     FULL_SLEEP_WAIT,
  input  wire logic                             SECOND_TICK,
  input  wire logic                             SET_DEEP_SLEEP_CMD,
  input  wire logic                             SET_HIBERNATE_CMD,
  input  wire logic                             OPEN_CIRCUIT_VOLTAGE_VALID,
  input  wire logic                             CELL_VOLTAGE_LOW,
  input  wire logic                             COMM_ACTIVITY,
  input  wire logic                             COMM_ADDR_MATCH,
  output logic                                  ALERT,
  output logic                                  SHUTDOWN_PIN_OUT,
  output logic                                  SHUTDOWN_PIN_OE_N,
  output logic                                  SINGLE_WIRE_HOST_PIN_OUT,
  output logic                                  SINGLE_WIRE_HOST_PIN_OE_N,
  output logic                                  COMM_STRETCH,
  output logic                                  CAL_REQ,
  output logic                                  MEASURE_ACTIVE,
  output gauge_pkg::power_mode_t                POWER_MODE,
  output logic                                  DEEP_SLEEP_BIT,
  output logic                                  HIBERNATE_BIT,
  output logic                                  SHUTDOWN_STATE
);
  import gauge_pkg::*;

  // Pin level for pullup/polarity/active: {level, oe_n}
  function automatic logic [1:0] pin_drive(input logic pu, input logic pol, input logic act);
    pin_drive = {pu & (pol ? act : ~act), ~pu & (act == pol)};
  endfunction : pin_drive

  function automatic logic [CUR_W-1:0] mag(input logic signed [CUR_W-1:0] v);
    mag = v[CUR_W-1] ? CUR_W'(-v) : CUR_W'(v);
  endfunction : mag

  // Pullup of the shutdown pin, and its polarity for the shutdown function, are captured once after reset
  logic pu_r, pol_r, strap_done_r;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      pu_r         <= PULLUP_RST;
      pol_r        <= POLARITY_RST;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      pu_r         <= SHUTDOWN_PIN_PULLUP;
      pol_r        <= ALERT_POLARITY;
      strap_done_r <= 1'b1;
    end
  end

  // Fault sources
  wire fault_always = CHARGE_THRESHOLD_ONE_FLAG | BATTERY_HIGH_FLAG | BATTERY_LOW_FLAG; // see R03
  wire fault_ot = (OVERTEMP_CHARGE_FLAG & (OVERTEMP_CHARGE_QUAL_TIME != '0))
                | (OVERTEMP_DISCHARGE_FLAG & (OVERTEMP_DISCHARGE_QUAL_TIME != '0)); // see R04
  wire fault_det = (INTERNAL_SHORT_FLAG & SHORT_ALERT_ENABLE)
                 | (TAB_DISCONNECT_FLAG & TAB_ALERT_ENABLE); // see R05
  wire fault_pk = PEAK_CURRENT_FLAG & PEAK_CURRENT_ALERT_ENABLE; // see R06
  wire fault_any = fault_always | fault_ot | fault_det | fault_pk;

  wire discharging = AVERAGE_CURRENT_B[CUR_W-1];
  wire charging    = ~AVERAGE_CURRENT_B[CUR_W-1] & (AVERAGE_CURRENT_B != '0);
  wire trip_hit = TRIP_POINT_ENABLE
                & ((discharging & (REMAINING_CAPACITY_A <= TRIP_SET_THRESHOLD))
                 | (charging & (REMAINING_CAPACITY_A >= TRIP_CLEAR_THRESHOLD))); // see R07

  // Trip alert latches; both threshold writes needed to release it
  logic trip_r, set_wr_r, clr_wr_r;
  wire set_seen = set_wr_r | TRIP_SET_WR;
  wire clr_seen = clr_wr_r | TRIP_CLEAR_WR;
  wire trip_release = trip_r & set_seen & clr_seen;
  wire trip_nxt = trip_hit | (trip_r & ~trip_release); // see R09
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      trip_r   <= 1'b0;
      set_wr_r <= 1'b0;
      clr_wr_r <= 1'b0;
    end else begin
      trip_r   <= trip_nxt;
      set_wr_r <= trip_r & set_seen & ~trip_release;
      clr_wr_r <= trip_r & clr_seen & ~trip_release;
    end
  end

  wire alert_nxt = TRIP_POINT_ENABLE ? trip_nxt : fault_any; // see R08

  // Power mode state
  power_mode_t mode_r, mode_nxt;
  logic cal_r, deep_r, hib_r, via_low_r;
  logic [WAIT_W-1:0] timer_r;
  logic [$clog2(STRETCH_CYCLES+1)-1:0] str_r;

  wire [CUR_W-1:0] avg_mag = mag(AVERAGE_CURRENT_B);
  wire sleep_ok  = SLEEP_ENABLE & (avg_mag < SLEEP_CURRENT); // see R11
  wire sleep_brk = (avg_mag > SLEEP_CURRENT) | (WAKE_CMP_ENABLE & WAKE_DETECT); // see R14
  wire hib_ok = OPEN_CIRCUIT_VOLTAGE_VALID & (avg_mag < HIBERNATE_CURRENT)
              & (CELL_VOLTAGE_LOW | hib_r); // see R20
  wire wait_zero = (FULL_SLEEP_WAIT == '0);
  wire in_normal = (mode_r == MODE_NORMAL);
  wire cal_go    = in_normal & ~cal_r & sleep_ok & ~hib_ok;
  wire cal_end   = in_normal & cal_r & CAL_DONE;
  wire to_deep   = wait_zero & (deep_r | SET_DEEP_SLEEP_CMD); // see R16
  wire hib_wake  = (mode_r == MODE_HIBERNATE) & COMM_ACTIVITY & COMM_ADDR_MATCH; // see R21
  wire deep_exit = (mode_r == MODE_DEEP_SLEEP_BIT) & (COMM_ACTIVITY | sleep_brk); // see R17 see R19
  wire timer_due = ~wait_zero & (timer_r == '0);

  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      MODE_NORMAL: begin // see R10
        if (hib_ok) begin
          mode_nxt = MODE_HIBERNATE;
        end else if (cal_end && sleep_ok) begin // see R12
          mode_nxt = to_deep ? MODE_DEEP_SLEEP_BIT : MODE_SLEEP;
        end
      end
      MODE_SLEEP: begin
        if (sleep_brk) begin // see R14
          mode_nxt = MODE_NORMAL;
        end else if (timer_due || to_deep) begin // see R15
          mode_nxt = MODE_DEEP_SLEEP_BIT;
        end
      end
      MODE_DEEP_SLEEP_BIT: begin
        if (deep_exit) begin
          mode_nxt = MODE_NORMAL;
        end
      end
      MODE_HIBERNATE: begin
        if (hib_wake) begin
          mode_nxt = MODE_NORMAL;
        end
      end
      default: mode_nxt = MODE_NORMAL;
    endcase
  end

  wire sleepish = (mode_r == MODE_SLEEP) | (mode_r == MODE_DEEP_SLEEP_BIT);
  // Deep sleep bit: command set wins over the exit clear
  wire deep_nxt = SET_DEEP_SLEEP_CMD | (deep_r & ~(deep_exit & wait_zero)); // see R17
  // Hibernate bit: command set wins over the wake clear
  wire hib_nxt  = SET_HIBERNATE_CMD | (hib_r & ~hib_wake); // see R23

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      mode_r <= MODE_RST; // see R25
    end else begin
      mode_r <= mode_nxt;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cal_r     <= 1'b0;
      deep_r    <= 1'b0;
      hib_r     <= 1'b0;
      via_low_r <= 1'b0;
    end else begin
      cal_r     <= (cal_r & in_normal & sleep_ok & ~CAL_DONE & ~hib_ok) | cal_go; // see R12
      deep_r    <= deep_nxt;
      hib_r     <= hib_nxt;
      via_low_r <= (in_normal & hib_ok) ? CELL_VOLTAGE_LOW : via_low_r; // see R22
    end
  end

  // Countdown only runs while in sleep; reloaded when calibration ends (cal_end)
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      timer_r <= '0;
    end else if (cal_end) begin
      timer_r <= FULL_SLEEP_WAIT;
    end else if (mode_r == MODE_SLEEP && SECOND_TICK && timer_r != '0) begin
      timer_r <= timer_r - 1'b1; // see R15
    end
  end

  // Transfer stretch: bounded, so a stuck line cannot hang the host
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      str_r <= '0;
    end else if (sleepish && COMM_ACTIVITY && str_r == '0) begin
      str_r <= ($bits(str_r))'(STRETCH_CYCLES); // see R13
    end else if (str_r != '0) begin
      str_r <= str_r - 1'b1;
    end
  end

  // Pins
  wire shut_state_nxt = ALERT_PIN_SELECT & SHUTDOWN_ENABLE
                      & (mode_nxt == MODE_HIBERNATE) & (in_normal ? CELL_VOLTAGE_LOW : via_low_r); // see R22
  wire [1:0] se_drv = ALERT_PIN_SELECT ? pin_drive(pu_r, pol_r, shut_state_nxt)
                                       : pin_drive(pu_r, ALERT_POLARITY, alert_nxt); // see R02
  wire [1:0] sw_drv = ALERT_PIN_SELECT ? pin_drive(1'b0, ALERT_POLARITY, alert_nxt)
                                       : 2'b01; // see R01

  logic alert_r, se_out_r, se_oe_n_r, sw_out_r, sw_oe_n_r, shut_r;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      alert_r   <= ALERT_RST;
      se_out_r  <= 1'b0;
      se_oe_n_r <= 1'b1;
      sw_out_r  <= 1'b0;
      sw_oe_n_r <= 1'b1;
      shut_r    <= 1'b0;
    end else begin
      alert_r   <= alert_nxt; // see R24
      se_out_r  <= se_drv[1];
      se_oe_n_r <= se_drv[0];
      sw_out_r  <= sw_drv[1];
      sw_oe_n_r <= sw_drv[0];
      shut_r    <= shut_state_nxt;
    end
  end

  assign ALERT                     = alert_r;
  assign SHUTDOWN_PIN_OUT          = se_out_r;
  assign SHUTDOWN_PIN_OE_N         = se_oe_n_r;
  assign SINGLE_WIRE_HOST_PIN_OUT  = sw_out_r;
  assign SINGLE_WIRE_HOST_PIN_OE_N = sw_oe_n_r;
  assign COMM_STRETCH              = (str_r != '0);
  assign CAL_REQ                   = cal_r;
  assign MEASURE_ACTIVE            = (mode_r != MODE_HIBERNATE);
  assign POWER_MODE                = mode_r;
  assign DEEP_SLEEP_BIT            = deep_r;
  assign HIBERNATE_BIT             = hib_r;
  assign SHUTDOWN_STATE            = shut_r;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  a_alert_follows: assert property (1'b1 |=> ALERT == $past(alert_nxt)) // see R24
    else $error("alert not one cycle after source");
  a_trip_masks: assert property (TRIP_POINT_ENABLE && !trip_nxt |=> !ALERT) // see R08
    else $error("non-trip source leaked in trip mode");
  a_always_srcs: assert property (!TRIP_POINT_ENABLE && BATTERY_LOW_FLAG |=> ALERT) // see R03
    else $error("low flag did not alert");
  a_trip_holds: assert property (trip_r && !TRIP_SET_WR && !set_wr_r |=> trip_r || trip_hit) // see R09
    else $error("trip alert dropped early");
  a_sleep_cal: assert property ($rose(mode_r == MODE_SLEEP) |-> $past(cal_r)) // see R12
    else $error("sleep without calibration");
  a_sleep_exit: assert property (mode_r == MODE_SLEEP && sleep_brk |=> mode_r == MODE_NORMAL) // see R14
    else $error("sleep not left");
  a_hib_stay: assert property (mode_r == MODE_HIBERNATE && !COMM_ACTIVITY |=> mode_r == MODE_HIBERNATE) // see R21
    else $error("hibernate left without traffic");
  a_hib_clear: assert property (hib_wake && !SET_HIBERNATE_CMD |=> !HIBERNATE_BIT ##1 (!HIBERNATE_BIT || $past(SET_HIBERNATE_CMD))) // see R23
    else $error("hibernate bit kept");
  a_stretch_len: assert property ($rose(COMM_STRETCH) |-> COMM_STRETCH [*8]) // see R13
    else $error("stretch too short");
  a_deep_zero: assert property ($rose(mode_r == MODE_DEEP_SLEEP_BIT) && wait_zero |-> $past(to_deep)) // see R16
    else $error("deep sleep without bit");
  c_trip: cover property (trip_r ##[1:50] !trip_r);
  c_deep: cover property (mode_r == MODE_SLEEP ##[1:300] mode_r == MODE_DEEP_SLEEP_BIT);
  c_hib: cover property (mode_r == MODE_HIBERNATE ##[1:100] mode_r == MODE_NORMAL);
endmodule : gauge_alert_power
`default_nettype wire

// file: verification/gauge_host_model.sv
`default_nettype none
module gauge_host_model (
  input  wire logic CORE_CLK,
  input  wire logic COMM_STRETCH,
  output var  logic COMM_ACTIVITY,
  output var  logic COMM_ADDR_MATCH,
  output var  logic SET_DEEP_SLEEP_CMD,
  output var  logic TRIP_SET_WR,
  output var  logic TRIP_CLEAR_WR
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {COMM_ACTIVITY, COMM_ADDR_MATCH, SET_DEEP_SLEEP_CMD, TRIP_SET_WR, TRIP_CLEAR_WR} = '0;
  end
  // One frame of traffic; addr_ok says whether it names this gauge
  task automatic transfer(input logic addr_ok, output logic held);
    int n;
    n = 0;
    @(negedge CORE_CLK);
    COMM_ACTIVITY = 1'b1;
    COMM_ADDR_MATCH = addr_ok;
    @(negedge CORE_CLK);
    {COMM_ACTIVITY, COMM_ADDR_MATCH} = 2'b00;
    @(negedge CORE_CLK);
    held = COMM_STRETCH;
    // Bounded, so a hold that never ends cannot hang the host
    while (COMM_STRETCH === 1'b1 && n < 64) begin
      @(negedge CORE_CLK);
      n++;
    end
  endtask : transfer
  // One-cycle strobes: deep sleep command, set write, clear write
  task automatic strobe(input logic [2:0] s);
    @(negedge CORE_CLK);
    {SET_DEEP_SLEEP_CMD, TRIP_SET_WR, TRIP_CLEAR_WR} = s;
    @(negedge CORE_CLK);
    {SET_DEEP_SLEEP_CMD, TRIP_SET_WR, TRIP_CLEAR_WR} = 3'b000;
  endtask : strobe
endmodule : gauge_host_model
`default_nettype wire

// file: verification/gauge_alert_power_tb.sv
`default_nettype none
module gauge_alert_power_tb;
  import gauge_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // Short hold keeps the run brief
  localparam int STRETCH = 16;
  logic CORE_CLK = '0, RST = '1, ALERT_PIN_SELECT = '0, ALERT_POLARITY = '0, SHUTDOWN_PIN_PULLUP = '0;
  logic SHUTDOWN_ENABLE = '0, CHARGE_THRESHOLD_ONE_FLAG = '0, BATTERY_HIGH_FLAG = '0, BATTERY_LOW_FLAG = '0;
  logic OVERTEMP_CHARGE_FLAG = '0, OVERTEMP_DISCHARGE_FLAG = '0, INTERNAL_SHORT_FLAG = '0;
  logic TAB_DISCONNECT_FLAG = '0, PEAK_CURRENT_FLAG = '0, SHORT_ALERT_ENABLE = '0, TAB_ALERT_ENABLE = '0;
  logic PEAK_CURRENT_ALERT_ENABLE = '0, TRIP_POINT_ENABLE = '0, SLEEP_ENABLE = '0, WAKE_CMP_ENABLE = '0;
  logic WAKE_DETECT = '0, CAL_DONE = '0, SECOND_TICK = '0, SET_HIBERNATE_CMD = '0;
  logic OPEN_CIRCUIT_VOLTAGE_VALID = '0, CELL_VOLTAGE_LOW = '0;
  logic [QT_W-1:0] OVERTEMP_CHARGE_QUAL_TIME = '0, OVERTEMP_DISCHARGE_QUAL_TIME = '0;
  logic [CAP_W-1:0] TRIP_SET_THRESHOLD = '0, TRIP_CLEAR_THRESHOLD = '0, REMAINING_CAPACITY_A = '0;
  logic signed [CUR_W-1:0] AVERAGE_CURRENT_B = '0;
  logic [CUR_W-1:0] SLEEP_CURRENT = '0, HIBERNATE_CURRENT = '0;
  logic [WAIT_W-1:0] FULL_SLEEP_WAIT = '0;
  logic COMM_ACTIVITY, COMM_ADDR_MATCH, SET_DEEP_SLEEP_CMD, TRIP_SET_WR, TRIP_CLEAR_WR;
  logic ALERT, SHUTDOWN_PIN_OUT, SHUTDOWN_PIN_OE_N, SINGLE_WIRE_HOST_PIN_OUT, SINGLE_WIRE_HOST_PIN_OE_N;
  logic COMM_STRETCH, CAL_REQ, MEASURE_ACTIVE, DEEP_SLEEP_BIT, HIBERNATE_BIT, SHUTDOWN_STATE;
  power_mode_t POWER_MODE;
  int errors = 0;
  int checks_done = 0;
  logic [31:0] seed = 32'h600bf1af;
  logic [7:0] f, e;
  logic held, a;
  // Level on each pin reduced to {released, driven high}
  wire logic [1:0] sw = {SINGLE_WIRE_HOST_PIN_OE_N, ~SINGLE_WIRE_HOST_PIN_OE_N & SINGLE_WIRE_HOST_PIN_OUT};
  wire logic [1:0] sd = {SHUTDOWN_PIN_OE_N, ~SHUTDOWN_PIN_OE_N & SHUTDOWN_PIN_OUT};

  always #12.5 CORE_CLK = ~CORE_CLK;

  gauge_alert_power #(.STRETCH_CYCLES(STRETCH)) i_gauge_alert_power (
    .CORE_CLK, .RST, .ALERT_PIN_SELECT, .ALERT_POLARITY, .SHUTDOWN_PIN_PULLUP, .SHUTDOWN_ENABLE,
    .CHARGE_THRESHOLD_ONE_FLAG, .BATTERY_HIGH_FLAG, .BATTERY_LOW_FLAG, .OVERTEMP_CHARGE_FLAG,
    .OVERTEMP_DISCHARGE_FLAG, .OVERTEMP_CHARGE_QUAL_TIME, .OVERTEMP_DISCHARGE_QUAL_TIME,
    .INTERNAL_SHORT_FLAG, .TAB_DISCONNECT_FLAG, .SHORT_ALERT_ENABLE, .TAB_ALERT_ENABLE,
    .PEAK_CURRENT_FLAG, .PEAK_CURRENT_ALERT_ENABLE, .TRIP_POINT_ENABLE, .TRIP_SET_THRESHOLD,
    .TRIP_CLEAR_THRESHOLD, .TRIP_SET_WR, .TRIP_CLEAR_WR, .REMAINING_CAPACITY_A, .AVERAGE_CURRENT_B,
    .SLEEP_CURRENT, .HIBERNATE_CURRENT, .SLEEP_ENABLE, .WAKE_CMP_ENABLE, .WAKE_DETECT, .CAL_DONE,
    .FULL_SLEEP_WAIT, .SECOND_TICK, .SET_DEEP_SLEEP_CMD, .SET_HIBERNATE_CMD, .OPEN_CIRCUIT_VOLTAGE_VALID,
    .CELL_VOLTAGE_LOW, .COMM_ACTIVITY, .COMM_ADDR_MATCH, .ALERT, .SHUTDOWN_PIN_OUT, .SHUTDOWN_PIN_OE_N,
    .SINGLE_WIRE_HOST_PIN_OUT, .SINGLE_WIRE_HOST_PIN_OE_N, .COMM_STRETCH, .CAL_REQ, .MEASURE_ACTIVE,
    .POWER_MODE, .DEEP_SLEEP_BIT, .HIBERNATE_BIT, .SHUTDOWN_STATE);

  gauge_host_model i_gauge_host_model (.CORE_CLK, .COMM_STRETCH, .COMM_ACTIVITY, .COMM_ADDR_MATCH,
    .SET_DEEP_SLEEP_CMD, .TRIP_SET_WR, .TRIP_CLEAR_WR);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Flag bits 2..0 have no gate; bits 7..3 pair with gates 4..0
  function automatic logic exp_alert(input logic [7:0] fl, input logic [7:0] en);
    return (|fl[2:0]) || (|(fl[7:3] & en[4:0]));
  endfunction : exp_alert

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic set_flags(input logic [7:0] v);
    {PEAK_CURRENT_FLAG, TAB_DISCONNECT_FLAG, INTERNAL_SHORT_FLAG, OVERTEMP_DISCHARGE_FLAG,
     OVERTEMP_CHARGE_FLAG, BATTERY_LOW_FLAG, BATTERY_HIGH_FLAG, CHARGE_THRESHOLD_ONE_FLAG} = v;
  endtask : set_flags

  task automatic cal();
    int n;
    n = 0;
    while (CAL_REQ !== 1'b1 && n < 20) begin
      @(negedge CORE_CLK);
      n++;
    end
    check({CAL_REQ, POWER_MODE}, {1'b1, MODE_NORMAL});
    CAL_DONE = 1'b1;
    @(negedge CORE_CLK);
    CAL_DONE = 1'b0;
  endtask : cal

  task automatic settle(input power_mode_t m);
    int n;
    n = 0;
    while (POWER_MODE !== m && n < 8) begin
      @(negedge CORE_CLK);
      n++;
    end
    check(POWER_MODE, m);
  endtask : settle

  task automatic report_and_stop();
    if (errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #(25 * 20000);
    errors++;
    report_and_stop();
  end

  initial begin
    repeat (16) @(negedge CORE_CLK);
    check({ALERT, SHUTDOWN_PIN_OE_N, SINGLE_WIRE_HOST_PIN_OE_N, POWER_MODE}, 16'h000c);
    RST = 1'b0;
    @(negedge CORE_CLK);
    repeat (64) begin
      seed = lfsr(seed);
      {f, e} = seed[15:0];
      set_flags(f);
      {PEAK_CURRENT_ALERT_ENABLE, TAB_ALERT_ENABLE, SHORT_ALERT_ENABLE} = e[4:2];
      OVERTEMP_CHARGE_QUAL_TIME = e[0] ? (seed[23:16] | 8'h01) : 8'h00;
      OVERTEMP_DISCHARGE_QUAL_TIME = e[1] ? (seed[31:24] | 8'h01) : 8'h00;
      {ALERT_PIN_SELECT, ALERT_POLARITY} = seed[17:16];
      a = exp_alert(f, e);
      @(negedge CORE_CLK);
      check(ALERT, a);
      if (ALERT_PIN_SELECT) check(sw, {a ~^ ALERT_POLARITY, 1'b0});
      else check({sd, sw[1]}, {a ~^ ALERT_POLARITY, 2'b01});
    end
    set_flags(8'h01);
    {TRIP_SET_THRESHOLD, TRIP_CLEAR_THRESHOLD, REMAINING_CAPACITY_A} = {16'h0100, 16'h0800, 16'h0101};
    AVERAGE_CURRENT_B = -16'sd40;
    TRIP_POINT_ENABLE = 1'b1;
    repeat (2) @(negedge CORE_CLK);
    check(ALERT, 1'b0);
    REMAINING_CAPACITY_A = 16'h0100;
    @(negedge CORE_CLK);
    check(ALERT, 1'b1);
    REMAINING_CAPACITY_A = 16'h0101;
    i_gauge_host_model.strobe(3'b010);
    repeat (3) @(negedge CORE_CLK);
    check(ALERT, 1'b1);
    i_gauge_host_model.strobe(3'b001);
    @(negedge CORE_CLK);
    check(ALERT, 1'b0);
    AVERAGE_CURRENT_B = 16'sd40;
    REMAINING_CAPACITY_A = 16'h0800;
    @(negedge CORE_CLK);
    check(ALERT, 1'b1);
    REMAINING_CAPACITY_A = 16'h07ff;
    i_gauge_host_model.strobe(3'b011);
    @(negedge CORE_CLK);
    check(ALERT, 1'b0);
    TRIP_POINT_ENABLE = 1'b0;
    set_flags(8'h00);
    {SLEEP_CURRENT, HIBERNATE_CURRENT, FULL_SLEEP_WAIT} = {16'h0010, 16'h0008, 8'h02};
    AVERAGE_CURRENT_B = -16'sd5;
    SLEEP_ENABLE = 1'b1;
    cal();
    check(POWER_MODE, MODE_SLEEP);
    repeat (3) begin
      SECOND_TICK = 1'b1;
      @(negedge CORE_CLK);
      SECOND_TICK = 1'b0;
      @(negedge CORE_CLK);
    end
    settle(MODE_DEEP_SLEEP_BIT);
    i_gauge_host_model.transfer(1'b1, held);
    check({held, POWER_MODE}, {1'b1, MODE_NORMAL});
    FULL_SLEEP_WAIT = 8'h00;
    i_gauge_host_model.strobe(3'b100);
    cal();
    check(POWER_MODE, MODE_DEEP_SLEEP_BIT);
    i_gauge_host_model.transfer(1'b1, held);
    check(DEEP_SLEEP_BIT, 1'b0);
    cal();
    check(POWER_MODE, MODE_SLEEP);
    AVERAGE_CURRENT_B = -16'sd17;
    settle(MODE_NORMAL);
    AVERAGE_CURRENT_B = -16'sd5;
    cal();
    {WAKE_CMP_ENABLE, WAKE_DETECT} = 2'b11;
    settle(MODE_NORMAL);
    {WAKE_CMP_ENABLE, WAKE_DETECT} = 2'b00;
    SLEEP_ENABLE = 1'b0;
    AVERAGE_CURRENT_B = -16'sd5;
    {ALERT_PIN_SELECT, SHUTDOWN_ENABLE, CELL_VOLTAGE_LOW, OPEN_CIRCUIT_VOLTAGE_VALID} = 4'hf;
    settle(MODE_HIBERNATE);
    @(negedge CORE_CLK);
    check({SHUTDOWN_STATE, MEASURE_ACTIVE}, 2'b10);
    CELL_VOLTAGE_LOW = 1'b0;
    i_gauge_host_model.transfer(1'b0, held);
    check(POWER_MODE, MODE_HIBERNATE);
    i_gauge_host_model.transfer(1'b1, held);
    check({POWER_MODE, MEASURE_ACTIVE}, {MODE_NORMAL, 1'b1});
    SET_HIBERNATE_CMD = 1'b1;
    @(negedge CORE_CLK);
    SET_HIBERNATE_CMD = 1'b0;
    settle(MODE_HIBERNATE);
    @(negedge CORE_CLK);
    check(SHUTDOWN_STATE, 1'b0);
    i_gauge_host_model.transfer(1'b1, held);
    check({POWER_MODE, HIBERNATE_BIT}, {MODE_NORMAL, 1'b0});
    // Second reset with the pull-up strap set; strap only takes effect after reset
    {RST, SHUTDOWN_PIN_PULLUP, ALERT_PIN_SELECT, TRIP_POINT_ENABLE} = 4'b1100;
    set_flags(8'h00);
    repeat (2) @(negedge CORE_CLK);
    check({sd, sw, POWER_MODE}, 6'h28);
    RST = 1'b0;
    @(negedge CORE_CLK);
    for (int i = 0; i < 4; i++) begin
      {ALERT_POLARITY, BATTERY_LOW_FLAG} = i[1:0];
      @(negedge CORE_CLK);
      check(sd, {1'b0, ALERT_POLARITY ~^ BATTERY_LOW_FLAG});
    end
    report_and_stop();
  end
endmodule : gauge_alert_power_tb
`default_nettype wire
